// ---- hdl/emhtp_device.sv ----
/*
  Device end: nine echo voice processors sharing one parallel host port and the TDM timing.
  Assumes all link pins come from another domain; each is synchronised before use.
*/
`timescale 1ns/1ps
`include "emhtp_defs.svh"

module emhtp_device (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Link
  emhtp_link_if.dev link
);
  localparam int NP = `EMHTP_NPROC;
  localparam int DW = `EMHTP_DATA_W;

  // Shared inputs, two flip-flops each, three for the serial clock
  logic [DW-1:0] data_s1, data_s2;
  logic [`EMHTP_ADDR_W-1:0] addr_s1, addr_s2;
  logic [NP-1:0] cs_s1, cs_s2;
  logic ds_s1, ds_s2, rw_s1, rw_s2;
  logic [NP-1:0] rin_s1, rin_s2, sin_s1, sin_s2;
  logic sclk_s1, sclk_s2, sclk_s3, fp_s1, fp_s2;
  logic [DW-1:0] frame_cnt_r;
  logic sclk_rise, sclk_fall;
  logic [NP*DW-1:0] rd_w;
  logic [NP-1:0] drv_w, ack_w, rout_w, sout_w;
  logic [DW-1:0] rd_any;
  logic [DW-1:0] data_d2h_r;
  logic data_d_oe_n_r;
  logic [NP-1:0] ack_oe_n_r, ack_out_r, rout_r, sout_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_s1 <= '0;
      data_s2 <= '0;
      addr_s1 <= '0;
      addr_s2 <= '0;
      cs_s1 <= '1;
      cs_s2 <= '1;
      ds_s1 <= 1'b1;
      ds_s2 <= 1'b1;
      rw_s1 <= 1'b1;
      rw_s2 <= 1'b1;
    end else begin
      data_s1 <= link.data_bus;
      data_s2 <= data_s1;
      addr_s1 <= link.addr;
      addr_s2 <= addr_s1;
      cs_s1 <= link.cs_n;
      cs_s2 <= cs_s1;
      ds_s1 <= link.data_strobe_n;
      ds_s2 <= ds_s1;
      rw_s1 <= link.rw;
      rw_s2 <= rw_s1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rin_s1 <= '1;
      rin_s2 <= '1;
      sin_s1 <= '1;
      sin_s2 <= '1;
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      fp_s1 <= 1'b1;
      fp_s2 <= 1'b1;
    end else begin
      rin_s1 <= link.rx_in;
      rin_s2 <= rin_s1;
      sin_s1 <= link.send_in;
      sin_s2 <= sin_s1;
      sclk_s1 <= link.serial_clk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      fp_s1 <= link.frame_pulse_n;
      fp_s2 <= fp_s1;
    end
  end

  assign sclk_rise = sclk_s2 & ~sclk_s3;
  assign sclk_fall = ~sclk_s2 & sclk_s3;

  // Frame pulse low marks the last bit of a 256-bit frame
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      frame_cnt_r <= '0;
    end else if (sclk_rise && !fp_s2) begin
      frame_cnt_r <= frame_cnt_r + 8'h01;
    end
  end

  for (genvar i = 0; i < NP; i++) begin : g_proc
    emhtp_pkg::emhtp_proc_state_type state_r;
    logic [DW-1:0] mem [0:`EMHTP_REG_DEPTH-1];
    logic prst_s1, prst_s2;
    logic [`EMHTP_REG_IDX_W-1:0] init_idx_r;
    logic [DW-1:0] rd_r;
    logic drv_r, ack_r, sel, standby, mute, in_map;

    // Own reset pin only; the others never reach this processor
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        prst_s1 <= 1'b0;
        prst_s2 <= 1'b0;
      end else begin
        prst_s1 <= link.proc_rst_n[i];
        prst_s2 <= prst_s1;
      end
    end

    assign sel = !cs_s2[i] && !ds_s2;
    assign in_map = addr_s2 < `EMHTP_ADDR_W'(`EMHTP_REG_DEPTH);
    assign standby = state_r == emhtp_pkg::EMHTP_P_STANDBY || state_r == emhtp_pkg::EMHTP_P_INIT;
    assign mute = mem[`EMHTP_REG_IDX_W'(`EMHTP_CTRL_ADDR)][`EMHTP_CTRL_MUTE_BIT];

    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        state_r <= emhtp_pkg::EMHTP_P_STANDBY;
        init_idx_r <= '0;
      end else if (!prst_s2) begin
        state_r <= emhtp_pkg::EMHTP_P_STANDBY;
        init_idx_r <= '0;
      end else begin
        case (state_r)
          emhtp_pkg::EMHTP_P_STANDBY: begin
            state_r <= emhtp_pkg::EMHTP_P_INIT;
          end
          emhtp_pkg::EMHTP_P_INIT: begin
            init_idx_r <= init_idx_r + 6'h01;
            if (init_idx_r == `EMHTP_REG_LAST) begin
              state_r <= emhtp_pkg::EMHTP_P_IDLE;
            end
          end
          emhtp_pkg::EMHTP_P_IDLE: begin
            if (sel) begin
              state_r <= emhtp_pkg::EMHTP_P_ACK;
            end
          end
          default: begin
            // Hold the acknowledge until the host ends the access
            if (!sel) begin
              state_r <= emhtp_pkg::EMHTP_P_IDLE;
            end
          end
        endcase
      end
    end

    // Registers are not cleared by the async reset; init walks them instead
    always_ff @(posedge clock) begin
      if (state_r == emhtp_pkg::EMHTP_P_INIT) begin
        mem[init_idx_r] <= `EMHTP_REG_RESET;
      end else if (state_r == emhtp_pkg::EMHTP_P_IDLE && sel && !rw_s2 && in_map
                   && addr_s2 != `EMHTP_STATUS_ADDR) begin
        mem[addr_s2[`EMHTP_REG_IDX_W-1:0]] <= data_s2;
      end
    end

    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        rd_r <= '0;
        drv_r <= 1'b0;
        ack_r <= 1'b0;
      end else if (!prst_s2 || !sel) begin
        drv_r <= 1'b0;
        ack_r <= 1'b0;
      end else if (state_r == emhtp_pkg::EMHTP_P_IDLE) begin
        ack_r <= 1'b1;
        drv_r <= rw_s2;
        if (addr_s2 == `EMHTP_STATUS_ADDR) begin
          rd_r <= frame_cnt_r;
        end else if (in_map) begin
          rd_r <= mem[addr_s2[`EMHTP_REG_IDX_W-1:0]];
        end else begin
          rd_r <= '0;
        end
      end
    end

    emhtp_tdm_lane u_rx_lane (
      .clock(clock),
      .rst(rst),
      .load_en(1'b0),
      .load_byte(`EMHTP_IDLE_BYTE),
      .shift_en(sclk_rise),
      .bit_in(rin_s2[i]),
      .out_en(sclk_fall),
      .idle(standby || mute),
      .bit_out(rout_w[i])
    );

    emhtp_tdm_lane u_send_lane (
      .clock(clock),
      .rst(rst),
      .load_en(1'b0),
      .load_byte(`EMHTP_IDLE_BYTE),
      .shift_en(sclk_rise),
      .bit_in(sin_s2[i]),
      .out_en(sclk_fall),
      .idle(standby || mute),
      .bit_out(sout_w[i])
    );

    assign rd_w[i*DW +: DW] = drv_r ? rd_r : '0;
    assign drv_w[i] = drv_r;
    assign ack_w[i] = ack_r;
  end

  always_comb begin
    rd_any = '0;
    for (int k = 0; k < NP; k++) begin
      rd_any = rd_any | rd_w[k*DW +: DW];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_d2h_r <= '0;
      data_d_oe_n_r <= 1'b1;
      ack_oe_n_r <= '1;
      ack_out_r <= '0;
      rout_r <= '1;
      sout_r <= '1;
    end else begin
      data_d2h_r <= rd_any;
      data_d_oe_n_r <= ~|drv_w;
      ack_oe_n_r <= ~ack_w;
      ack_out_r <= '0;
      rout_r <= rout_w;
      sout_r <= sout_w;
    end
  end

  assign link.data_d2h = data_d2h_r;
  assign link.data_d_oe_n = data_d_oe_n_r;
  assign link.transfer_ack_oe_n = ack_oe_n_r;
  assign link.transfer_ack_out = ack_out_r;
  assign link.rx_out = rout_r;
  assign link.send_out = sout_r;
endmodule // emhtp_device

// ---- hdl/emhtp_defs.svh ----
/*
  Shared constants of the multi-processor host port and TDM link.
  Assumes inclusion by bare name from every file that needs it.
*/
`ifndef EMHTP_DEFS_SVH
`define EMHTP_DEFS_SVH

`define EMHTP_NPROC 9
`define EMHTP_DATA_W 8
`define EMHTP_ADDR_W 13
`define EMHTP_REG_DEPTH 64
`define EMHTP_REG_IDX_W 6
`define EMHTP_REG_LAST 6'h3f
`define EMHTP_CTRL_ADDR 13'h0000
`define EMHTP_CTRL_MUTE_BIT 0
`define EMHTP_STATUS_ADDR 13'h0001
`define EMHTP_REG_RESET 8'h00
`define EMHTP_IDLE_BYTE 8'hff
`define EMHTP_LINK_DIV 3'h7
`define EMHTP_LINK_HALF 3'h4
`define EMHTP_LINK_OUT 3'h5
`define EMHTP_FRAME_LAST 8'hff
`define EMHTP_ACK_TIMEOUT 8'hff

`endif

// ---- hdl/emhtp_pkg.sv ----
/*
  Types of the multi-processor host port and TDM link.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package emhtp_pkg;

  typedef enum logic [1:0] {
    EMHTP_P_STANDBY = 2'b00,
    EMHTP_P_INIT = 2'b01,
    EMHTP_P_IDLE = 2'b10,
    EMHTP_P_ACK = 2'b11
  } emhtp_proc_state_type;

  typedef enum logic [2:0] {
    EMHTP_H_IDLE = 3'b000,
    EMHTP_H_SETUP = 3'b001,
    EMHTP_H_STROBE = 3'b010,
    EMHTP_H_RELEASE = 3'b011,
    EMHTP_H_DONE = 3'b100
  } emhtp_host_state_type;

endpackage

// ---- hdl/emhtp_link_if.sv ----
/*
  Pins between the host end and the nine-processor device end.
  Assumes the bench joins both ends; shared data and acknowledge lines are resolved here
  with an idle-high pull.
*/
`timescale 1ns/1ps
`include "emhtp_defs.svh"

interface emhtp_link_if;
  logic [`EMHTP_DATA_W-1:0] data_h2d;
  logic data_h_oe_n;
  logic [`EMHTP_DATA_W-1:0] data_d2h;
  logic data_d_oe_n;
  logic [`EMHTP_DATA_W-1:0] data_bus;
  logic [`EMHTP_ADDR_W-1:0] addr;
  logic [`EMHTP_NPROC-1:0] cs_n;
  logic data_strobe_n;
  logic rw;
  logic [`EMHTP_NPROC-1:0] transfer_ack_out;
  logic [`EMHTP_NPROC-1:0] transfer_ack_oe_n;
  logic [`EMHTP_NPROC-1:0] transfer_ack_n;
  logic [`EMHTP_NPROC-1:0] proc_rst_n;
  logic [`EMHTP_NPROC-1:0] rx_in;
  logic [`EMHTP_NPROC-1:0] send_in;
  logic [`EMHTP_NPROC-1:0] rx_out;
  logic [`EMHTP_NPROC-1:0] send_out;
  logic serial_clk;
  logic frame_pulse_n;
  logic scan_test_enable;
  logic scan_test_fast_clock;
  logic scan_test_input;
  logic scan_test_reset;
  logic scan_test_set;
  logic test_halt_in;
  logic test_single_step_in;

  // Pull-up stands in for the board resistor when nobody drives
  assign data_bus = !data_h_oe_n ? data_h2d : (!data_d_oe_n ? data_d2h : `EMHTP_IDLE_BYTE);
  assign transfer_ack_n = ~(~transfer_ack_oe_n & ~transfer_ack_out);

  modport dev (
    input data_bus, addr, cs_n, data_strobe_n, rw, proc_rst_n, rx_in, send_in,
    input serial_clk, frame_pulse_n, scan_test_enable, scan_test_fast_clock,
    input scan_test_input, scan_test_reset, scan_test_set, test_halt_in, test_single_step_in,
    output data_d2h, data_d_oe_n, transfer_ack_out, transfer_ack_oe_n, rx_out, send_out
  );

  modport host (
    input data_bus, transfer_ack_n, rx_out, send_out,
    output data_h2d, data_h_oe_n, addr, cs_n, data_strobe_n, rw, proc_rst_n, rx_in, send_in,
    output serial_clk, frame_pulse_n, scan_test_enable, scan_test_fast_clock,
    output scan_test_input, scan_test_reset, scan_test_set, test_halt_in, test_single_step_in
  );
endinterface

// ---- hdl/emhtp_tdm_lane.sv ----
/*
  One serial TDM lane: an 8-bit shift register with a registered serial output.
  Assumes the enables are one-cycle pulses on the same clock.
*/
`timescale 1ns/1ps
`include "emhtp_defs.svh"

module emhtp_tdm_lane (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic load_en,
  input wire logic [`EMHTP_DATA_W-1:0] load_byte,
  input wire logic shift_en,
  input wire logic bit_in,
  input wire logic out_en,
  input wire logic idle,
  // Serial output
  output logic bit_out
);
  logic [`EMHTP_DATA_W-1:0] sr_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sr_r <= `EMHTP_IDLE_BYTE;
    end else if (load_en) begin
      sr_r <= load_byte;
    end else if (shift_en) begin
      sr_r <= {sr_r[`EMHTP_DATA_W-2:0], bit_in};
    end
  end

  // Idle line sits high so an absent stream reads as all ones
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bit_out <= 1'b1;
    end else if (idle) begin
      bit_out <= 1'b1;
    end else if (out_en) begin
      bit_out <= sr_r[`EMHTP_DATA_W-1];
    end
  end
endmodule // emhtp_tdm_lane

// ---- hdl/emhtp_host.sv ----
/*
  Host end: drives the shared parallel port, the processor resets, the serial clock,
  frame pulse and the two TDM input streams of every processor.
  Assumes user-side requests come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "emhtp_defs.svh"

module emhtp_host (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Access request
  input wire logic req,
  input wire logic req_rw,
  input wire logic [3:0] req_proc,
  input wire logic [`EMHTP_ADDR_W-1:0] req_addr,
  input wire logic [`EMHTP_DATA_W-1:0] req_wdata,
  // Access answer
  output logic busy,
  output logic done,
  output logic err,
  output logic [`EMHTP_DATA_W-1:0] rdata,
  // Processor resets, one bit each, active high
  input wire logic [`EMHTP_NPROC-1:0] proc_reset,
  // TDM source bytes
  input wire logic [`EMHTP_DATA_W-1:0] rx_byte,
  input wire logic [`EMHTP_DATA_W-1:0] send_byte,
  output logic slot_load,
  output logic [4:0] slot_num,
  // Link
  emhtp_link_if.host link
);
  localparam int NP = `EMHTP_NPROC;

  emhtp_pkg::emhtp_host_state_type state_r;
  logic [NP-1:0] ack_s1, ack_s2;
  logic [`EMHTP_DATA_W-1:0] data_s1, data_s2;
  logic [NP-1:0] cs_n_r, rst_n_r;
  logic [`EMHTP_ADDR_W-1:0] addr_r;
  logic [`EMHTP_DATA_W-1:0] wdata_r;
  logic [3:0] proc_r;
  logic rw_r, ds_n_r, data_oe_n_r, ack_seen;
  logic [7:0] tmo_r;
  logic [2:0] div_r;
  logic [7:0] bit_r;
  logic sclk_r, fp_n_r, load_w, out_w, shift_w, rx_bit, send_bit;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_s1 <= '1;
      ack_s2 <= '1;
      data_s1 <= '0;
      data_s2 <= '0;
    end else begin
      ack_s1 <= link.transfer_ack_n;
      ack_s2 <= ack_s1;
      data_s1 <= link.data_bus;
      data_s2 <= data_s1;
    end
  end

  assign ack_seen = !ack_s2[proc_r];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= emhtp_pkg::EMHTP_H_IDLE;
      cs_n_r <= '1;
      ds_n_r <= 1'b1;
      rw_r <= 1'b1;
      data_oe_n_r <= 1'b1;
      addr_r <= '0;
      wdata_r <= '0;
      proc_r <= '0;
      tmo_r <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      err <= 1'b0;
      rdata <= '0;
    end else begin
      done <= 1'b0;
      case (state_r)
        emhtp_pkg::EMHTP_H_IDLE: begin
          if (req) begin
            busy <= 1'b1;
            err <= 1'b0;
            proc_r <= 4'(req_proc < 4'(NP) ? req_proc : 4'h0);
            if (req_proc < 4'(NP)) begin
              cs_n_r <= ~(NP'(1) << req_proc);
              addr_r <= req_addr;
              rw_r <= req_rw;
              wdata_r <= req_wdata;
              data_oe_n_r <= req_rw;
              state_r <= emhtp_pkg::EMHTP_H_SETUP;
            end else begin
              err <= 1'b1;
              state_r <= emhtp_pkg::EMHTP_H_DONE;
            end
          end
        end
        emhtp_pkg::EMHTP_H_SETUP: begin
          // Address, select and data settle one cycle before the strobe
          ds_n_r <= 1'b0;
          tmo_r <= '0;
          state_r <= emhtp_pkg::EMHTP_H_STROBE;
        end
        emhtp_pkg::EMHTP_H_STROBE: begin
          tmo_r <= tmo_r + 8'h01;
          if (ack_seen || tmo_r == `EMHTP_ACK_TIMEOUT) begin
            rdata <= rw_r ? data_s2 : '0;
            err <= !ack_seen;
            ds_n_r <= 1'b1;
            cs_n_r <= '1;
            data_oe_n_r <= 1'b1;
            tmo_r <= '0;
            state_r <= emhtp_pkg::EMHTP_H_RELEASE;
          end
        end
        emhtp_pkg::EMHTP_H_RELEASE: begin
          // Wait for the release so the next access cannot see a stale acknowledge
          tmo_r <= tmo_r + 8'h01;
          if (!ack_seen || tmo_r == `EMHTP_ACK_TIMEOUT) begin
            state_r <= emhtp_pkg::EMHTP_H_DONE;
          end
        end
        default: begin
          busy <= 1'b0;
          done <= 1'b1;
          state_r <= emhtp_pkg::EMHTP_H_IDLE;
        end
      endcase
    end
  end

  // Resets and test pins; the latter never leave ground
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rst_n_r <= '0;
    end else begin
      rst_n_r <= ~proc_reset;
    end
  end

  // Serial clock of 8 system clocks; rise at div 0, fall at div 4
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_r <= `EMHTP_LINK_DIV;
      sclk_r <= 1'b0;
      bit_r <= `EMHTP_FRAME_LAST;
      fp_n_r <= 1'b1;
      slot_load <= 1'b0;
      slot_num <= '0;
    end else begin
      div_r <= (div_r == `EMHTP_LINK_DIV) ? 3'h0 : div_r + 3'h1;
      sclk_r <= (div_r == `EMHTP_LINK_DIV) || (div_r < `EMHTP_LINK_HALF - 3'h1);
      if (div_r == `EMHTP_LINK_DIV) begin
        bit_r <= bit_r + 8'h01;
      end
      if (out_w) begin
        fp_n_r <= bit_r != `EMHTP_FRAME_LAST;
      end
      slot_load <= load_w;
      if (load_w) begin
        slot_num <= bit_r[7:3];
      end
    end
  end

  assign load_w = div_r == `EMHTP_LINK_HALF && bit_r[2:0] == 3'h0;
  assign out_w = div_r == `EMHTP_LINK_OUT;
  assign shift_w = div_r == 3'h0;

  emhtp_tdm_lane u_rx_src (
    .clock(clock),
    .rst(rst),
    .load_en(load_w),
    .load_byte(rx_byte),
    .shift_en(shift_w),
    .bit_in(1'b1),
    .out_en(out_w),
    .idle(1'b0),
    .bit_out(rx_bit)
  );

  emhtp_tdm_lane u_send_src (
    .clock(clock),
    .rst(rst),
    .load_en(load_w),
    .load_byte(send_byte),
    .shift_en(shift_w),
    .bit_in(1'b1),
    .out_en(out_w),
    .idle(1'b0),
    .bit_out(send_bit)
  );

  assign link.data_h2d = wdata_r;
  assign link.data_h_oe_n = data_oe_n_r;
  assign link.addr = addr_r;
  assign link.cs_n = cs_n_r;
  assign link.data_strobe_n = ds_n_r;
  assign link.rw = rw_r;
  assign link.proc_rst_n = rst_n_r;
  assign link.rx_in = {NP{rx_bit}};
  assign link.send_in = {NP{send_bit}};
  assign link.serial_clk = sclk_r;
  assign link.frame_pulse_n = fp_n_r;
  assign link.scan_test_enable = 1'b0;
  assign link.scan_test_fast_clock = 1'b0;
  assign link.scan_test_input = 1'b0;
  assign link.scan_test_reset = 1'b0;
  assign link.scan_test_set = 1'b0;
  assign link.test_halt_in = 1'b0;
  assign link.test_single_step_in = 1'b0;
endmodule // emhtp_host

// ---- tb/emhtp_link_sva.sv ----
/*
  Concurrent checks on the link between the host end and the device end.
  Assumes plain copies of the interface signals and one clock with an active-high reset.
*/
`timescale 1ns/1ps
`include "emhtp_defs.svh"

module emhtp_link_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Parallel port
  input wire logic data_h_oe_n,
  input wire logic data_d_oe_n,
  input wire logic rw,
  input wire logic data_strobe_n,
  input wire logic [`EMHTP_NPROC-1:0] cs_n,
  input wire logic [`EMHTP_NPROC-1:0] transfer_ack_oe_n,
  input wire logic [`EMHTP_NPROC-1:0] proc_rst_n,
  // Serial side
  input wire logic [`EMHTP_NPROC-1:0] rx_out,
  input wire logic [`EMHTP_NPROC-1:0] send_out,
  input wire logic serial_clk,
  input wire logic frame_pulse_n,
  // Test pins
  input wire logic scan_test_enable,
  input wire logic scan_test_fast_clock,
  input wire logic scan_test_input,
  input wire logic scan_test_reset,
  input wire logic scan_test_set,
  input wire logic test_halt_in,
  input wire logic test_single_step_in
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // Cycles since the last frame marker; wraps only far beyond one frame
  logic [11:0] fr_cnt_r;
  logic fr_seen_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fr_cnt_r <= 12'h000;
      fr_seen_r <= 1'b0;
    end else if ($fell(frame_pulse_n)) begin
      fr_cnt_r <= 12'h000;
      fr_seen_r <= 1'b1;
    end else begin
      fr_cnt_r <= fr_cnt_r + 12'h001;
    end
  end

  test_pins_low_a: assert property (!(scan_test_enable | scan_test_fast_clock | scan_test_input |
    scan_test_reset | scan_test_set | test_halt_in | test_single_step_in))
    else $error("test pin driven active");
  strobe_one_sel_a: assert property (!data_strobe_n |-> $onehot(~cs_n))
    else $error("strobe without exactly one select");
  host_drive_dir_a: assert property (!data_h_oe_n |-> !rw && !data_d_oe_n === 1'b0)
    else $error("host drives data bus outside a write");
  unsel_release_a: assert property (&cs_n [*6] |-> &transfer_ack_oe_n && data_d_oe_n)
    else $error("unselected processor still drives");
  ack_cause_a: assert property ($fell(&transfer_ack_oe_n) |-> !$past(data_strobe_n, 3))
    else $error("acknowledge without strobe");
  ack_answer_a: assert property ($fell(data_strobe_n) && ((~cs_n & proc_rst_n) != 0)
    |-> ##[2:8] !(&transfer_ack_oe_n))
    else $error("selected processor gave no acknowledge");
  ack_hold_a: assert property (!(&transfer_ack_oe_n) && !data_strobe_n |=> !(&transfer_ack_oe_n))
    else $error("acknowledge dropped while strobe low");
  standby_idle_a: assert property (!proc_rst_n[2] [*8] |-> rx_out[2] && send_out[2])
    else $error("processor in standby drives a stream");
  bit_clock_a: assert property ($rose(serial_clk) |-> serial_clk [*4] ##1 !serial_clk [*4] ##1 serial_clk)
    else $error("serial clock period wrong");
  frame_mark_a: assert property ($fell(frame_pulse_n) |-> !frame_pulse_n [*8] ##1 frame_pulse_n)
    else $error("frame marker not one bit long");
  frame_len_a: assert property ($fell(frame_pulse_n) && fr_seen_r |-> fr_cnt_r == 12'h7ff)
    else $error("frame is not 256 bits long");

  cover property ($fell(&transfer_ack_oe_n) && rw);
  cover property ($fell(&transfer_ack_oe_n) && !rw);
  cover property ($fell(frame_pulse_n) && fr_seen_r);
endmodule // emhtp_link_sva

// ---- tb/tb_multi_processor_host_and_tdm_port.sv ----
/*
  Self-checking bench joining the host end and the device end through the link interface.
  Assumes the design files and the link checker are compiled before it.
*/
`timescale 1ns/1ps
`include "emhtp_defs.svh"

module tb_multi_processor_host_and_tdm_port;
  logic clock;
  logic rst;
  logic req;
  logic req_rw;
  logic [3:0] req_proc;
  logic [12:0] req_addr;
  logic [7:0] req_wdata;
  logic busy;
  logic done;
  logic err;
  logic [7:0] rdata;
  logic [8:0] proc_reset;
  logic [7:0] rx_byte;
  logic [7:0] send_byte;
  logic slot_load;
  logic [4:0] slot_num;
  logic [7:0] got_data;
  logic got_err;
  logic [23:0] w_rx [0:8];
  logic [23:0] w_send [0:8];
  int mismatches;
  int total_checks;

  emhtp_link_if link ();
  emhtp_device emhtp_device_inst (.clock(clock), .rst(rst), .link(link.dev));
  emhtp_host emhtp_host_inst (.clock(clock), .rst(rst), .req(req), .req_rw(req_rw), .req_proc(req_proc),
    .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy), .done(done), .err(err), .rdata(rdata),
    .proc_reset(proc_reset), .rx_byte(rx_byte), .send_byte(send_byte), .slot_load(slot_load), .slot_num(slot_num),
    .link(link.host));
  emhtp_link_sva emhtp_link_sva_inst (.clock(clock), .rst(rst), .data_h_oe_n(link.data_h_oe_n),
    .data_d_oe_n(link.data_d_oe_n), .rw(link.rw), .data_strobe_n(link.data_strobe_n), .cs_n(link.cs_n),
    .transfer_ack_oe_n(link.transfer_ack_oe_n), .proc_rst_n(link.proc_rst_n), .rx_out(link.rx_out),
    .send_out(link.send_out), .serial_clk(link.serial_clk), .frame_pulse_n(link.frame_pulse_n),
    .scan_test_enable(link.scan_test_enable), .scan_test_fast_clock(link.scan_test_fast_clock),
    .scan_test_input(link.scan_test_input), .scan_test_reset(link.scan_test_reset),
    .scan_test_set(link.scan_test_set), .test_halt_in(link.test_halt_in),
    .test_single_step_in(link.test_single_step_in));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic wrap_up;
    if (mismatches == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // One user request, held for a single cycle, then a bounded wait for completion
  task automatic access(input logic rw_i, input logic [3:0] p, input logic [12:0] a, input logic [7:0] d);
    int k;
    @(negedge clock);
    req = 1'b1;
    req_rw = rw_i;
    req_proc = p;
    req_addr = a;
    req_wdata = d;
    @(negedge clock);
    req = 1'b0;
    check1(busy, 1'b1, "busy while pending");
    k = 0;
    while (done !== 1'b1 && k < 700) begin
      @(negedge clock);
      k++;
    end
    if (done !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED at %0t: access never completed", $time);
      wrap_up();
    end
    check1(busy, 1'b0, "busy after done");
    got_data = rdata;
    got_err = err;
  endtask

  task automatic read_expect(input logic [3:0] p, input logic [12:0] a, input logic [7:0] exp);
    access(1'b1, p, a, 8'h00);
    check8(got_data, exp, "read data");
    check1(got_err, 1'b0, "error flag");
  endtask

  // Collects 24 bits of every output stream at rising serial clock edges
  task automatic sample_streams;
    int n;
    int k;
    logic prev;
    n = 0;
    prev = link.serial_clk;
    for (k = 0; k < 400 && n < 24; k++) begin
      @(negedge clock);
      if (link.serial_clk === 1'b1 && prev === 1'b0) begin
        for (int p = 0; p < 9; p++) begin
          w_rx[p] = {w_rx[p][22:0], link.rx_out[p]};
          w_send[p] = {w_send[p][22:0], link.send_out[p]};
        end
        n++;
      end
      prev = link.serial_clk;
    end
    if (n < 24) begin
      mismatches++;
      $display("CHECK FAILED at %0t: serial clock stalled", $time);
      wrap_up();
    end
  endtask

  // True when two consecutive byte windows at one alignment hold the byte
  function automatic logic has_byte(input logic [23:0] w, input logic [7:0] b);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 8; i++)
      if (w[i +: 8] === b && w[i + 8 +: 8] === b)
        hit = 1'b1;
    return hit;
  endfunction

  task automatic test_rw_select;
    logic [3:0] p;
    for (p = 4'h0; p < 4'h9; p = p + 4'h4)
      access(1'b0, p, 13'h0002 + {9'h000, p}, 8'ha0 | {4'h0, p});
    for (p = 4'h0; p < 4'h9; p = p + 4'h4) begin
      read_expect(p, 13'h0002 + {9'h000, p}, 8'ha0 | {4'h0, p});
      if (p != 4'h8)
        read_expect(p + 4'h1, 13'h0002 + {9'h000, p}, 8'h00);
    end
  endtask

  task automatic test_address_decode;
    access(1'b0, 4'h0, 13'h1003, 8'hc3);
    read_expect(4'h0, 13'h0003, 8'h00);
    read_expect(4'h0, 13'h1003, 8'h00);
    access(1'b0, 4'h0, 13'h003f, 8'h81);
    read_expect(4'h0, 13'h003f, 8'h81);
  endtask

  task automatic test_proc_reset;
    access(1'b0, 4'h2, 13'h0005, 8'h77);
    access(1'b0, 4'h3, 13'h0005, 8'h66);
    @(negedge clock);
    proc_reset[2] = 1'b1;
    repeat (10) @(negedge clock);
    sample_streams();
    check8(w_rx[2][7:0] & w_rx[2][15:8] & w_rx[2][23:16], 8'hff, "standby receive out");
    check8(w_send[2][7:0] & w_send[2][15:8] & w_send[2][23:16], 8'hff, "standby send out");
    access(1'b1, 4'h2, 13'h0005, 8'h00);
    check1(got_err, 1'b1, "standby access refused");
    @(negedge clock);
    proc_reset[2] = 1'b0;
    repeat (100) @(negedge clock);
    read_expect(4'h2, 13'h0005, 8'h00);
    read_expect(4'h3, 13'h0005, 8'h66);
  endtask

  task automatic test_tdm_streams;
    repeat (200) @(negedge clock);
    sample_streams();
    for (int p = 0; p < 9; p++) begin
      check1(has_byte(w_rx[p], 8'ha5), 1'b1, "receive stream");
      check1(has_byte(w_send[p], 8'h3c), 1'b1, "send stream");
    end
    access(1'b0, 4'h6, `EMHTP_CTRL_ADDR, 8'h01);
    sample_streams();
    check8(w_rx[6][7:0] & w_rx[6][15:8] & w_send[6][7:0] & w_send[6][15:8], 8'hff, "muted");
    access(1'b0, 4'h6, `EMHTP_CTRL_ADDR, 8'h00);
  endtask

  // Each frame marker adds one to status, and slot 0 loads while the marker stands
  task automatic test_frame_status;
    logic [7:0] s0;
    int k;
    for (int f = 0; f < 2; f++) begin
      repeat (20) @(negedge clock);
      k = 0;
      while ((link.frame_pulse_n !== 1'b0 || slot_load !== 1'b1) && k < 2200) begin
        @(negedge clock);
        k++;
      end
      if (slot_load !== 1'b1) begin
        mismatches++;
        $display("CHECK FAILED at %0t: no frame marker", $time);
        wrap_up();
      end
      check8({3'h0, slot_num}, 8'h00, "first slot of frame");
      if (f == 0) begin
        access(1'b1, 4'h0, `EMHTP_STATUS_ADDR, 8'h00);
        s0 = got_data;
      end
    end
    read_expect(4'h0, `EMHTP_STATUS_ADDR, s0 + 8'h01);
  endtask

  initial begin
    mismatches = 0;
    total_checks = 0;
    rst = 1'b1;
    req = 1'b0;
    req_rw = 1'b0;
    req_proc = 4'h0;
    req_addr = 13'h0000;
    req_wdata = 8'h00;
    proc_reset = 9'h000;
    rx_byte = 8'ha5;
    send_byte = 8'h3c;
    repeat (12) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    // Processors need their init pass after reset before they answer
    repeat (100) @(negedge clock);
    test_rw_select();
    test_address_decode();
    test_tdm_streams();
    test_proc_reset();
    test_frame_status();
    wrap_up();
  end
endmodule // tb_multi_processor_host_and_tdm_port
